// >>> logic/ispx_pkg.sv
// Shared constants, types and decode function of the serial programming port.
package ispx_pkg;

	// ==========================================================
	// Timing
	localparam real ISPX_CLK_NS       = 10.0;
	localparam real FLASH_WAIT_MS     = 4.5;
	localparam real EEPROM_WAIT_MS    = 4.0;
	localparam real ERASE_WAIT_MS     = 4.0;
	localparam real FUSE_WAIT_MS      = 4.5;
	localparam real POWERUP_WAIT_MS   = 20.0;
	localparam real RESET_PULSE_NS    = 320.0;
	localparam int  FLASH_WAIT_CYC    = int'($ceil(FLASH_WAIT_MS * 1.0E6 / ISPX_CLK_NS));
	localparam int  EEPROM_WAIT_CYC   = int'($ceil(EEPROM_WAIT_MS * 1.0E6 / ISPX_CLK_NS));
	localparam int  ERASE_WAIT_CYC    = int'($ceil(ERASE_WAIT_MS * 1.0E6 / ISPX_CLK_NS));
	localparam int  FUSE_WAIT_CYC     = int'($ceil(FUSE_WAIT_MS * 1.0E6 / ISPX_CLK_NS));
	localparam int  POWERUP_WAIT_CYC  = int'($ceil(POWERUP_WAIT_MS * 1.0E6 / ISPX_CLK_NS));
	localparam int  RESET_PULSE_CYC   = int'($ceil(RESET_PULSE_NS / ISPX_CLK_NS));
	localparam int  SCK_HALF_CYC      = 8;

	// ==========================================================
	// Memory layout
	localparam int  PAGE_WORD_BITS    = 5;
	localparam int  PAGE_SEL_BITS     = 6;
	localparam int  FLASH_ADDR_BITS   = PAGE_WORD_BITS + PAGE_SEL_BITS;
	localparam int  EE_ADDR_BITS      = 6;
	localparam int  EE_PAGE_BITS      = 2;
	localparam int  SIG_IDX_BITS      = 2;
	localparam int  FRAME_BITS        = 32;
	localparam logic [4:0] CNT_ECHO   = 5'h10;
	localparam logic [4:0] CNT_DATA   = 5'h18;
	localparam logic [4:0] CNT_LAST   = 5'h1F;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	localparam logic [7:0] FUSE_LOW_RST = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST  = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] LOCK_RST     = 8'hFF;

	// ==========================================================
	// Instruction codes
	localparam logic [7:0] OPC_AC       = 8'hAC;
	localparam logic [7:0] SUB_ENABLE   = 8'h53;
	localparam logic [7:0] SUB_ERASE    = 8'h80;
	localparam logic [7:0] SUB_WR_LOCK  = 8'hE0;
	localparam logic [7:0] SUB_WR_FLOW  = 8'hA0;
	localparam logic [7:0] SUB_WR_FHI   = 8'hA8;
	localparam logic [7:0] SUB_WR_FEXT  = 8'hA4;
	localparam logic [7:0] SUB_HI_SEL   = 8'h08;
	localparam logic [7:0] OPC_POLL     = 8'hF0;
	localparam logic [7:0] OPC_LD_HI    = 8'h48;
	localparam logic [7:0] OPC_LD_LO    = 8'h40;
	localparam logic [7:0] OPC_WR_PAGE  = 8'h4C;
	localparam logic [7:0] OPC_RD_HI    = 8'h28;
	localparam logic [7:0] OPC_RD_LO    = 8'h20;
	localparam logic [7:0] OPC_EE_RD    = 8'hA0;
	localparam logic [7:0] OPC_EE_WR    = 8'hC0;
	localparam logic [7:0] OPC_EE_LD    = 8'hC1;
	localparam logic [7:0] OPC_EE_PAGE  = 8'hC2;
	localparam logic [7:0] OPC_RD_LOCK  = 8'h58;
	localparam logic [7:0] OPC_RD_FUSE  = 8'h50;
	localparam logic [7:0] OPC_RD_SIG   = 8'h30;
	localparam logic [7:0] OPC_RD_CAL   = 8'h38;

	typedef enum logic [4:0] {
		OP_NONE, OP_ENABLE, OP_ERASE, OP_POLL, OP_LD_HI, OP_LD_LO,
		OP_WR_PAGE, OP_RD_HI, OP_RD_LO, OP_EE_RD, OP_EE_WR, OP_EE_LD,
		OP_EE_PAGE, OP_RD_LOCK, OP_RD_FLOW, OP_RD_FHI, OP_RD_FEXT,
		OP_RD_SIG, OP_RD_CAL, OP_WR_LOCK, OP_WR_FLOW, OP_WR_FHI,
		OP_WR_FEXT
	} ispx_op_t;

	typedef enum logic [1:0] {
		WAIT_FLASH, WAIT_EEPROM, WAIT_ERASE, WAIT_FUSE
	} ispx_wait_t;

	// Classifies an instruction from its first two bytes.
	function automatic ispx_op_t ispx_decode(input logic [7:0] b1,
		input logic [7:0] b2);
		ispx_op_t op;
		op = OP_NONE;
		case (b1)
			OPC_AC:
			begin
				case (b2)
					SUB_ENABLE:  op = OP_ENABLE;
					SUB_ERASE:   op = OP_ERASE;
					SUB_WR_LOCK: op = OP_WR_LOCK;
					SUB_WR_FLOW: op = OP_WR_FLOW;
					SUB_WR_FHI:  op = OP_WR_FHI;
					SUB_WR_FEXT: op = OP_WR_FEXT;
					default:     op = OP_NONE;
				endcase
			end
			OPC_POLL:    op = OP_POLL;
			OPC_LD_HI:   op = OP_LD_HI;
			OPC_LD_LO:   op = OP_LD_LO;
			OPC_WR_PAGE: op = OP_WR_PAGE;
			OPC_RD_HI:   op = OP_RD_HI;
			OPC_RD_LO:   op = OP_RD_LO;
			OPC_EE_RD:   op = OP_EE_RD;
			OPC_EE_WR:   op = OP_EE_WR;
			OPC_EE_LD:   op = OP_EE_LD;
			OPC_EE_PAGE: op = OP_EE_PAGE;
			OPC_RD_LOCK: op = (b2 == SUB_HI_SEL) ? OP_RD_FHI : OP_RD_LOCK;
			OPC_RD_FUSE: op = (b2 == SUB_HI_SEL) ? OP_RD_FEXT : OP_RD_FLOW;
			OPC_RD_SIG:  op = OP_RD_SIG;
			OPC_RD_CAL:  op = OP_RD_CAL;
			default:     op = OP_NONE;
		endcase
		return op;
	endfunction

endpackage

// >>> logic/ispx_if.sv
// Link wires between the programmer and the programmed device.
`timescale 1ns/1ps
interface ispx_if;
	logic sck;
	logic mosi;
	logic miso;
	logic dev_reset_n;

	modport dev (input sck, input mosi, input dev_reset_n, output miso);
	modport prog (output sck, output mosi, output dev_reset_n, input miso);
endinterface

// >>> logic/ispx_sync.sv
// Three-flop synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module ispx_sync #(
	parameter logic INIT = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Data
	input  wire logic d,
	output logic      q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic q_q;

	// ==========================================================
	// Stages
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q_q  <= INIT;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				q_q <= s3_q;
		end
	end

	assign q = q_q;
endmodule // ispx_sync

// >>> logic/ispx_device.sv
// Device end: serial instruction decoder, memories, fuses and write timers.
`timescale 1ns/1ps

// Overview of operation
// RQ1: Program and erase refused until enable accepted.
// RQ2: Serial input sampled on rising clock edge.
// RQ3: Serial output changes on falling clock edge.
// RQ4: Programmer holds clock phases long enough.
// RQ5: Programmer keeps reset and clock low.
// RQ6: Programmer waits 20 ms before enabling.
// RQ7: Echo enable second byte during third byte.
// RQ8: Programmer always sends four bytes, retries.
// RQ9: Flash buffer load uses low five bits.
// RQ10: Programmer loads low byte before high.
// RQ11: Page write uses upper six bits; wait.
// RQ12: EEPROM byte write overwrites location; wait.
// RQ13: EEPROM page load uses low two bits.
// RQ14: EEPROM page write changes loaded bytes only.
// RQ15: Chip erase sets all memory to FF.
// RQ16: Poll returns pending flag in byte four.
// RQ17: Flash load opcodes 48 high, 40 low.
// RQ18: Flash read opcodes 28 high, 20 low.
// RQ19: EEPROM read, write, load, page opcodes.
// RQ20: Lock, fuse, signature, calibration read codes.
// RQ21: Lock and fuse write codes, zero programs.
// RQ22: Program addresses are word addresses.
// RQ23: Bytes MSB first, four-byte frames.
// RQ24: Reset high ends session, drops frame.
module ispx_device
	import ispx_pkg::*;
#(
	parameter int         FLASH_WAIT  = FLASH_WAIT_CYC,
	parameter int         EEPROM_WAIT = EEPROM_WAIT_CYC,
	parameter int         ERASE_WAIT  = ERASE_WAIT_CYC,
	parameter int         FUSE_WAIT   = FUSE_WAIT_CYC,
	parameter logic [7:0] SIG0        = 8'h5A,
	parameter logic [7:0] SIG1        = 8'h3C,
	parameter logic [7:0] SIG2        = 8'h0F,
	parameter logic [7:0] CAL_BYTE    = 8'h80
) (
	// Link
	ispx_if.dev           link,
	// System
	input  wire logic     ref_clk,
	input  wire logic     rst_n,
	// Status
	output logic          busy,
	output logic [7:0]    fuse_low,
	output logic [7:0]    fuse_high,
	output logic [7:0]    fuse_ext,
	output logic [7:0]    lock_bits
);
	// Signature and calibration defaults above are arbitrary values.

	localparam int FLASH_WORDS = 1 << FLASH_ADDR_BITS;
	localparam int PAGE_WORDS  = 1 << PAGE_WORD_BITS;
	localparam int EE_BYTES    = 1 << EE_ADDR_BITS;
	localparam int EE_PAGE     = 1 << EE_PAGE_BITS;

	logic                       sess_rst_n;
	logic [4:0]                 cnt_q;
	logic [30:0]                sh_q;
	logic                       en_q;
	logic [31:0]                word;
	ispx_op_t                   op;
	ispx_op_t                   rd_op;
	logic                       frame_end;
	logic                       wr_ok;
	logic [FLASH_ADDR_BITS-1:0] f_addr;
	logic [FLASH_ADDR_BITS-1:0] rd_faddr;
	logic [15:0]                flash_q [FLASH_WORDS];
	logic [15:0]                fbuf_q [PAGE_WORDS];
	logic [7:0]                 ee_q [EE_BYTES];
	logic [7:0]                 ebuf_q [EE_PAGE];
	logic [EE_PAGE-1:0]         eload_q;
	logic [7:0]                 fuse_low_q;
	logic [7:0]                 fuse_high_q;
	logic [7:0]                 fuse_ext_q;
	logic [7:0]                 lock_q;
	logic                       tgl_q;
	ispx_wait_t                 kind_q;
	logic                       pend_s;
	logic [7:0]                 rd_byte;
	logic [6:0]                 tx_q;
	logic                       miso_q;
	logic                       tgl_s;
	logic                       tgl_d_q;
	logic [31:0]                wait_q;
	logic                       busy_q;

	// ==========================================================
	// Frame receive on the link clock
	assign sess_rst_n = rst_n & ~link.dev_reset_n;                 // RQ24
	assign word       = {sh_q, link.mosi};                          // RQ23
	assign op         = ispx_decode(word[31:24], word[23:16]);
	assign frame_end  = (cnt_q == CNT_LAST);
	assign wr_ok      = frame_end && en_q;                          // RQ1
	assign f_addr     = word[FLASH_ADDR_BITS+7:8];                  // RQ22

	always_ff @(posedge link.sck or negedge sess_rst_n)
	begin
		if (!sess_rst_n)
		begin
			cnt_q <= 5'h00;
			sh_q  <= 31'h0000_0000;
		end
		else
		begin
			cnt_q <= cnt_q + 5'h01;
			sh_q  <= word[30:0];                                    // RQ2
		end
	end

	always_ff @(posedge link.sck or negedge sess_rst_n)
	begin
		if (!sess_rst_n)
			en_q <= 1'b0;
		else if (frame_end && op == OP_ENABLE)
			en_q <= 1'b1;                                           // RQ1
	end

	// ==========================================================
	// Flash and its page buffer
	always_ff @(posedge link.sck)
	begin
		if (wr_ok)
		begin
			case (op)
				OP_LD_LO: fbuf_q[f_addr[PAGE_WORD_BITS-1:0]][7:0] <= word[7:0];   // RQ9 RQ17
				OP_LD_HI: fbuf_q[f_addr[PAGE_WORD_BITS-1:0]][15:8] <= word[7:0];  // RQ9 RQ17
				OP_WR_PAGE:
				begin
					for (int i = 0; i < PAGE_WORDS; i++)
						flash_q[{f_addr[FLASH_ADDR_BITS-1:PAGE_WORD_BITS],
							PAGE_WORD_BITS'(i)}] <= fbuf_q[i];                   // RQ11
					for (int j = 0; j < PAGE_WORDS; j++)
						fbuf_q[j] <= {ERASED_BYTE, ERASED_BYTE};
				end
				OP_ERASE:
				begin
					for (int i = 0; i < FLASH_WORDS; i++)
						flash_q[i] <= {ERASED_BYTE, ERASED_BYTE};                // RQ15
					for (int j = 0; j < PAGE_WORDS; j++)
						fbuf_q[j] <= {ERASED_BYTE, ERASED_BYTE};
				end
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// EEPROM and its page buffer
	always_ff @(posedge link.sck)
	begin
		if (wr_ok)
		begin
			case (op)
				OP_EE_WR: ee_q[word[EE_ADDR_BITS+7:8]] <= word[7:0];              // RQ12 RQ19
				OP_EE_LD: ebuf_q[word[EE_PAGE_BITS+7:8]] <= word[7:0];            // RQ13 RQ19
				OP_EE_PAGE:
				begin
					for (int i = 0; i < EE_PAGE; i++)
						if (eload_q[i])
							ee_q[{word[EE_ADDR_BITS+7:EE_PAGE_BITS+8],
								EE_PAGE_BITS'(i)}] <= ebuf_q[i];                 // RQ14
				end
				OP_ERASE:
				begin
					for (int i = 0; i < EE_BYTES; i++)
						ee_q[i] <= ERASED_BYTE;                                  // RQ15
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge link.sck or negedge sess_rst_n)
	begin
		if (!sess_rst_n)
			eload_q <= '0;
		else if (wr_ok && op == OP_EE_PAGE)
			eload_q <= '0;                                              // RQ14
		else if (wr_ok && op == OP_EE_LD)
			eload_q[word[EE_PAGE_BITS+7:8]] <= 1'b1;                    // RQ14
	end

	// ==========================================================
	// Fuses and lock bits
	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fuse_low_q  <= FUSE_LOW_RST;
			fuse_high_q <= FUSE_HI_RST;
			fuse_ext_q  <= FUSE_EXT_RST;
			lock_q      <= LOCK_RST;
		end
		else if (wr_ok)
		begin
			case (op)
				OP_WR_LOCK: lock_q      <= word[7:0];                   // RQ21
				OP_WR_FLOW: fuse_low_q  <= word[7:0];                   // RQ21
				OP_WR_FHI:  fuse_high_q <= word[7:0];                   // RQ21
				OP_WR_FEXT: fuse_ext_q  <= word[7:0];                   // RQ21
				OP_ERASE:   lock_q      <= LOCK_RST;                    // RQ15
				default:    lock_q      <= lock_q;
			endcase
		end
	end

	assign fuse_low  = fuse_low_q;
	assign fuse_high = fuse_high_q;
	assign fuse_ext  = fuse_ext_q;
	assign lock_bits = lock_q;

	// ==========================================================
	// Write start event toward the timer
	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tgl_q  <= 1'b0;
			kind_q <= WAIT_FLASH;
		end
		else if (wr_ok)
		begin
			case (op)
				OP_WR_PAGE:
				begin
					tgl_q  <= ~tgl_q;
					kind_q <= WAIT_FLASH;                               // RQ11
				end
				OP_EE_WR, OP_EE_PAGE:
				begin
					tgl_q  <= ~tgl_q;
					kind_q <= WAIT_EEPROM;                              // RQ12
				end
				OP_ERASE:
				begin
					tgl_q  <= ~tgl_q;
					kind_q <= WAIT_ERASE;
				end
				OP_WR_LOCK, OP_WR_FLOW, OP_WR_FHI, OP_WR_FEXT:
				begin
					tgl_q  <= ~tgl_q;
					kind_q <= WAIT_FUSE;
				end
				default:
				begin
				end
			endcase
		end
	end

	ispx_sync u_pend_sync (
		.clk   (link.sck),
		.rst_n (rst_n),
		.d     (busy_q),
		.q     (pend_s)
	);

	// ==========================================================
	// Answer byte on the falling link clock
	assign rd_op    = ispx_decode(sh_q[23:16], sh_q[15:8]);
	assign rd_faddr = sh_q[FLASH_ADDR_BITS-1:0];                    // RQ22

	always_comb
	begin
		case (rd_op)
			OP_POLL:    rd_byte = {7'h00, pend_s};                      // RQ16
			OP_RD_HI:   rd_byte = flash_q[rd_faddr][15:8];              // RQ18
			OP_RD_LO:   rd_byte = flash_q[rd_faddr][7:0];               // RQ18
			OP_EE_RD:   rd_byte = ee_q[sh_q[EE_ADDR_BITS-1:0]];         // RQ19
			OP_RD_LOCK: rd_byte = lock_q;                               // RQ20
			OP_RD_FLOW: rd_byte = fuse_low_q;                           // RQ20
			OP_RD_FHI:  rd_byte = fuse_high_q;                          // RQ20
			OP_RD_FEXT: rd_byte = fuse_ext_q;                           // RQ20
			OP_RD_CAL:  rd_byte = CAL_BYTE;                             // RQ20
			OP_RD_SIG:
			begin
				case (sh_q[SIG_IDX_BITS-1:0])
					2'h0:    rd_byte = SIG0;                            // RQ20
					2'h1:    rd_byte = SIG1;
					2'h2:    rd_byte = SIG2;
					default: rd_byte = ERASED_BYTE;
				endcase
			end
			default:    rd_byte = 8'h00;
		endcase
	end

	always_ff @(negedge link.sck or negedge sess_rst_n)
	begin
		if (!sess_rst_n)
		begin
			miso_q <= 1'b0;
			tx_q   <= 7'h00;
		end
		else if (cnt_q == CNT_ECHO)
		begin
			miso_q <= sh_q[7];                                      // RQ7
			tx_q   <= sh_q[6:0];                                    // RQ7
		end
		else if (cnt_q == CNT_DATA)
		begin
			miso_q <= rd_byte[7];                                   // RQ3
			tx_q   <= rd_byte[6:0];
		end
		else
		begin
			miso_q <= tx_q[6];                                      // RQ3
			tx_q   <= {tx_q[5:0], 1'b0};
		end
	end

	assign link.miso = miso_q;

	// ==========================================================
	// Self-timed write wait on the reference clock
	ispx_sync u_tgl_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (tgl_q),
		.q     (tgl_s)
	);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tgl_d_q <= 1'b0;
			wait_q  <= 32'h0000_0000;
			busy_q  <= 1'b0;
		end
		else
		begin
			tgl_d_q <= tgl_s;
			if (tgl_s != tgl_d_q)
			begin
				busy_q <= 1'b1;                                     // RQ16
				case (kind_q)
					WAIT_FLASH:  wait_q <= 32'(FLASH_WAIT);
					WAIT_EEPROM: wait_q <= 32'(EEPROM_WAIT);
					WAIT_ERASE:  wait_q <= 32'(ERASE_WAIT);
					default:     wait_q <= 32'(FUSE_WAIT);
				endcase
			end
			else if (wait_q > 32'h0000_0001)
				wait_q <= wait_q - 32'h0000_0001;
			else
			begin
				wait_q <= 32'h0000_0000;
				busy_q <= 1'b0;
			end
		end
	end

	assign busy = busy_q;
endmodule // ispx_device

// >>> logic/ispx_prog.sv
// Programmer end: session control, clock divider and four-byte frame shifter.
`timescale 1ns/1ps
module ispx_prog
	import ispx_pkg::*;
#(
	parameter int POWERUP_WAIT = POWERUP_WAIT_CYC,
	parameter int PULSE_CYC    = RESET_PULSE_CYC,
	parameter int HALF_CYC     = SCK_HALF_CYC
) (
	// Link
	ispx_if.prog        link,
	// System
	input  wire logic   ref_clk,
	input  wire logic   rst_n,
	// Session
	input  wire logic   sess_req,
	// Command
	input  wire logic   cmd_valid,
	input  wire logic [31:0] cmd_word,
	output logic        cmd_ready,
	// Answer
	output logic        rsp_valid,
	output logic [7:0]  rsp_echo,
	output logic [7:0]  rsp_data,
	output logic        sync_err
);
	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_WAKE  = 5'b00010,
		ST_IDLE  = 5'b00100,
		ST_SHIFT = 5'b01000,
		ST_PULSE = 5'b10000
	} ispx_state_t;

	ispx_state_t state_q;
	logic        sck_q;
	logic        mosi_q;
	logic        rstn_q;
	logic        ready_q;
	logic        valid_q;
	logic        err_q;
	logic [7:0]  echo_q;
	logic [7:0]  data_q;
	logic [31:0] tx_q;
	logic [31:0] rx_q;
	logic [4:0]  bit_q;
	logic [31:0] tmr_q;
	logic        is_en_q;
	logic        miso_s;

	ispx_sync u_miso_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (link.miso),
		.q     (miso_s)
	);

	// ==========================================================
	// Session and frame sequencer
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_OFF;
			sck_q   <= 1'b0;
			mosi_q  <= 1'b0;
			rstn_q  <= 1'b1;
			ready_q <= 1'b0;
			valid_q <= 1'b0;
			err_q   <= 1'b0;
			echo_q  <= 8'h00;
			data_q  <= 8'h00;
			tx_q    <= 32'h0000_0000;
			rx_q    <= 32'h0000_0000;
			bit_q   <= 5'h00;
			tmr_q   <= 32'h0000_0000;
			is_en_q <= 1'b0;
		end
		else
		begin
			valid_q <= 1'b0;
			err_q   <= 1'b0;
			case (state_q)
				ST_OFF:
				begin
					sck_q <= 1'b0;
					if (sess_req)
					begin
						rstn_q  <= 1'b0;                            // RQ5
						tmr_q   <= 32'(POWERUP_WAIT);               // RQ6
						state_q <= ST_WAKE;
					end
				end
				ST_WAKE:
				begin
					if (tmr_q > 32'h0000_0001)
						tmr_q <= tmr_q - 32'h0000_0001;             // RQ6
					else
					begin
						ready_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE:
				begin
					if (!sess_req)
					begin
						ready_q <= 1'b0;
						rstn_q  <= 1'b1;
						state_q <= ST_OFF;
					end
					else if (cmd_valid)
					begin
						ready_q <= 1'b0;
						tx_q    <= cmd_word;
						mosi_q  <= cmd_word[31];                    // RQ23
						is_en_q <= (cmd_word[31:16] == {OPC_AC, SUB_ENABLE});
						bit_q   <= 5'h00;
						tmr_q   <= 32'h0000_0000;
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					if (tmr_q < 32'(HALF_CYC - 1))
						tmr_q <= tmr_q + 32'h0000_0001;             // RQ4
					else
					begin
						tmr_q <= 32'h0000_0000;
						if (!sck_q)
						begin
							sck_q <= 1'b1;
							rx_q  <= {rx_q[30:0], miso_s};
						end
						else
						begin
							sck_q <= 1'b0;
							if (bit_q == CNT_LAST)
							begin
								valid_q <= 1'b1;                    // RQ8
								echo_q  <= rx_q[15:8];
								data_q  <= rx_q[7:0];
								if (is_en_q && rx_q[15:8] != SUB_ENABLE)
								begin
									err_q   <= 1'b1;
									rstn_q  <= 1'b1;                // RQ8
									state_q <= ST_PULSE;
								end
								else
								begin
									ready_q <= 1'b1;
									state_q <= ST_IDLE;
								end
							end
							else
							begin
								bit_q  <= bit_q + 5'h01;
								mosi_q <= tx_q[30];
								tx_q   <= {tx_q[30:0], 1'b0};
							end
						end
					end
				end
				ST_PULSE:
				begin
					if (tmr_q < 32'(PULSE_CYC - 1))
						tmr_q <= tmr_q + 32'h0000_0001;             // RQ5
					else
					begin
						rstn_q  <= 1'b0;
						ready_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default:
				begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	assign link.sck         = sck_q;
	assign link.mosi        = mosi_q;
	assign link.dev_reset_n = rstn_q;
	assign cmd_ready        = ready_q;
	assign rsp_valid        = valid_q;
	assign rsp_echo         = echo_q;
	assign rsp_data         = data_q;
	assign sync_err         = err_q;
endmodule // ispx_prog

// >>> verification/ispx_monitor.sv
// Link checker for the serial programming port.
`timescale 1ns/1ps
module ispx_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic dev_reset_n
);
	// ==========================================================
	// Frame capture
	logic        sck_q;
	logic [4:0]  n_q;
	logic        done_q;
	logic [31:0] so_q;
	logic [31:0] si_q;
	wire         rise = sck & ~sck_q;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			sck_q <= 1'b0;
		else
			sck_q <= sck;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			n_q <= 5'h00;
		else if (dev_reset_n)
			n_q <= 5'h00;
		else if (rise)
			n_q <= n_q + 5'h01;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			done_q <= 1'b0;
		else
			done_q <= rise & (n_q == 5'h1F) & ~dev_reset_n;

	always_ff @(posedge ref_clk)
		if (rise)
		begin
			so_q <= {so_q[30:0], mosi};
			si_q <= {si_q[30:0], miso};
		end

	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
		else $error("mosi moved while sck high");
	AST_MISO_FALL: assert property ((!dev_reset_n && $changed(miso)) |-> $fell(sck))
		else $error("miso moved off the sck falling edge");
	AST_SCK_HIGH: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("sck high phase wrong");
	AST_SCK_LOW: assert property ($fell(sck) |-> !sck[*8])
		else $error("sck low phase too short");
	AST_SCK_IDLE: assert property (dev_reset_n |-> !sck)
		else $error("sck high outside session");
	AST_PULSE: assert property ($fell(dev_reset_n) |-> $past(dev_reset_n, 2))
		else $error("reset pulse too short");
	AST_ECHO: assert property (done_q |-> si_q[15:8] == so_q[23:16])
		else $error("second byte not echoed");
	AST_MISO_IDLE: assert property (dev_reset_n |-> !miso)
		else $error("miso driven outside session");

	cover property (done_q && so_q[31:16] == 16'hAC53);
	cover property ($fell(dev_reset_n));
	cover property (done_q && so_q[31:24] == 8'hF0 && si_q[0]);
endmodule // ispx_monitor

// >>> verification/tb_serial_isp_programming_port.sv
// Bench driving a programmer end into a device end.
`timescale 1ns/1ps
module tb_serial_isp_programming_port;
	// ==========================================================
	// Harness
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sess_req = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [31:0] cmd_word = 32'h0;
	logic        cmd_ready, rsp_valid, sync_err, busy;
	logic [7:0]  rsp_echo, rsp_data, f_lo, f_hi, f_ext, lck;
	logic [7:0]  d, e, lo, v;
	logic [5:0]  p;
	logic [4:0]  w;
	logic [7:0]  fs [4] = '{8'hA0, 8'hA8, 8'hA4, 8'hE0};
	logic [15:0] fr [4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
	logic [7:0]  sg [4] = '{8'h5A, 8'h3C, 8'h0F, 8'h80};
	logic [7:0]  fv [4];
	logic [7:0]  mem [8];
	int          err_count = 0;
	int          check_count = 0;
	int          seed = 9;
	int          i;

	ispx_if ifc ();
	ispx_prog #(.POWERUP_WAIT(20)) ispx_prog_i (.link(ifc.prog),
		.ref_clk(ref_clk), .rst_n(rst_n), .sess_req(sess_req),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_echo(rsp_echo), .rsp_data(rsp_data),
		.sync_err(sync_err));
	ispx_device #(.FLASH_WAIT(3000), .EEPROM_WAIT(3000),
		.ERASE_WAIT(3000), .FUSE_WAIT(3000)) ispx_device_i (
		.link(ifc.dev), .ref_clk(ref_clk), .rst_n(rst_n), .busy(busy),
		.fuse_low(f_lo), .fuse_high(f_hi), .fuse_ext(f_ext),
		.lock_bits(lck));
	ispx_monitor ispx_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.sck(ifc.sck), .mosi(ifc.mosi), .miso(ifc.miso),
		.dev_reset_n(ifc.dev_reset_n));

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, x, input string m);
		check_count++;
		if (g !== x)
		begin
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
			err_count++;
		end
	endtask

	task automatic lost();
		$display("[ERR] %0t wait ran out", $time);
		err_count++;
		results();
	endtask

	task automatic cmd(input logic [31:0] c);
		int n;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_word <= c;
		n = 0;
		do @(negedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 200);
		if (cmd_ready !== 1'b1)
			lost();
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		n = 0;
		do @(negedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 600);
		if (rsp_valid !== 1'b1)
			lost();
		d = rsp_data;
		e = rsp_echo;
	endtask

	task automatic idle();
		for (int n = 0; n < 20; n++)
		begin
			cmd(32'hF000_0000);
			if (d[0] === 1'b0)
				return;
		end
		lost();
	endtask

	initial
		forever #5 ref_clk = ~ref_clk;

	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		sess_req <= 1'b1;
		cmd(32'hAC53_0000);
		chk(e, 8'h53, "echo");
		cmd(32'hAC80_0000);
		idle();
		cmd(32'hC000_05A5);
		idle();
		@(posedge ref_clk);
		sess_req <= 1'b0;
		repeat (40) @(posedge ref_clk);
		sess_req <= 1'b1;
		cmd(32'hAC80_0000);
		cmd(32'hC000_055A);
		cmd(32'hAC53_0000);
		cmd(32'hA000_0500);
		chk(d, 8'hA5, "refused");
		cmd(32'hA000_0600);
		chk(d, 8'hFF, "erased");
		$display("session test done");
		p = 6'($random(seed));
		for (i = 0; i < 8; i++)
		begin
			w = 5'((i * 9) % 32);
			mem[i] = 8'($random(seed));
			cmd({8'h40, 5'h00, p, w, mem[i]});
			cmd({8'h48, 5'h00, p, w, mem[i] ^ 8'h5C});
		end
		cmd({8'h4C, 5'h00, p, 5'h13, 8'h00});
		cmd(32'h3000_0000);
		cmd(32'hF000_0000);
		chk(d & 8'h01, 8'h01, "pending");
		chk({7'h00, busy}, 8'h01, "busy");
		idle();
		for (i = 0; i < 8; i++)
		begin
			w = 5'((i * 9) % 32);
			cmd({8'h20, 5'h00, p, w, 8'h00});
			chk(d, mem[i], "flash lo");
			cmd({8'h28, 5'h00, p, w, 8'h00});
			chk(d, mem[i] ^ 8'h5C, "flash hi");
		end
		cmd({8'h20, 5'h00, p, 5'h01, 8'h00});
		chk(d, 8'hFF, "unloaded");
		$display("flash test done");
		lo = 8'($random(seed));
		cmd({24'hC10000, lo});
		cmd({24'hC10002, ~lo});
		cmd(32'hC200_0C00);
		idle();
		for (i = 0; i < 4; i++)
		begin
			cmd({16'hA000, 8'(12 + i), 8'h00});
			v = (i == 0) ? lo : (i == 2) ? ~lo : 8'hFF;
			chk(d, v, "ee page");
		end
		cmd({24'hC00021, ~lo});
		idle();
		cmd({24'hC00021, lo});
		idle();
		cmd(32'hA000_2100);
		chk(d, lo, "ee byte");
		$display("eeprom test done");
		for (i = 0; i < 4; i++)
		begin
			fv[i] = 8'($random(seed));
			cmd({8'hAC, fs[i], 8'h00, fv[i]});
			idle();
			cmd({fr[i], 16'h0000});
			chk(d, fv[i], "fuse");
			cmd(i < 3 ? {8'h30, 14'h0, i[1:0], 8'h00} : 32'h3800_0000);
			chk(d, sg[i], "id");
		end
		chk(f_lo, fv[0], "low");
		chk(f_hi, fv[1], "high");
		chk(f_ext, fv[2], "ext");
		chk(lck, fv[3], "lock");
		$display("fuse test done");
		results();
	end
endmodule // tb_serial_isp_programming_port
